/* File: rtl/sic_pkg.sv */
package sic_pkg;

  // Bus geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 32;
  localparam int SFR_W = 8;

  // Register indices, word address on the bus equals the index
  localparam logic [2:0] IDX_IRQ_ENABLE_ONE = 3'h0;
  localparam logic [2:0] IDX_IRQ_ENABLE_TWO = 3'h1;
  localparam logic [2:0] IDX_IRQ_FLAG_ONE = 3'h2;
  localparam logic [2:0] IDX_IRQ_FLAG_TWO = 3'h3;
  localparam logic [2:0] IDX_MODULE_ENABLE_ONE = 3'h4;
  localparam logic [2:0] IDX_MODULE_ENABLE_TWO = 3'h5;
  localparam logic [2:0] IDX_SLEEP_CTRL = 3'h6;
  localparam logic [2:0] IDX_SLEEP_STAT = 3'h7;

  // Implemented bits of each byte register
  localparam logic [7:0] IE1_MASK = 8'hF3;
  localparam logic [7:0] IRQ_FLAG_ONE_MASK = 8'hDF;
  localparam logic [7:0] ME1_MASK = 8'hC0;

  // Flag bits touched by the power-up clear and their values
  localparam logic [7:0] IRQ_FLAG_ONE_PUC_MASK = 8'hD2;
  localparam logic [7:0] IRQ_FLAG_ONE_PUC_VAL = 8'h82;
  localparam logic [7:0] IRQ_FLAG_ONE_POR_VAL = 8'h86;
  localparam logic [7:0] IE1_RST_VAL = 8'h00;
  localparam logic [7:0] ME1_RST_VAL = 8'h00;

  // Bit positions in the enable, flag and module enable bytes
  localparam int BIT_SER_TX = 7;
  localparam int BIT_SER_RX = 6;
  localparam int BIT_FLASH_VIOL = 5;
  localparam int BIT_PIN_NMI = 4;
  localparam int BIT_EXT_RESET = 3;
  localparam int BIT_POWER_ON = 2;
  localparam int BIT_OSC_FAULT = 1;
  localparam int BIT_WDOG = 0;

  // Own control and status fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DCO_USED_BIT = 3;
  localparam int STAT_PEND_BIT = 4;
  localparam logic [2:0] MODE_CODE_MAX = 3'h5;

  // Vector table and address map
  localparam logic [15:0] VEC_BASE_ADDR = 16'hFFE0;
  localparam logic [15:0] RESET_VEC_ADDR = 16'hFFFE;
  localparam logic [15:0] BLANK_WORD = 16'hFFFF;
  localparam logic [15:0] SFR_REGION_END = 16'h01FF;
  localparam logic [15:0] RAM_END = 16'h03FF;
  localparam logic [15:0] INFO_START = 16'h1000;
  localparam logic [15:0] INFO_END = 16'h10FF;
  localparam logic [15:0] CODE_START = 16'hC000;

  // Vector priorities
  localparam int NUM_PRIO = 16;
  localparam int PRIO_RESET = 15;
  localparam int PRIO_NMI = 14;
  localparam int PRIO_ADC = 12;
  localparam int PRIO_WDOG = 10;
  localparam int PRIO_SER_RX = 9;
  localparam int PRIO_SER_TX = 8;
  localparam int PRIO_TMR_CC0 = 6;
  localparam int PRIO_TMR_GRP = 5;
  localparam int PRIO_PORT1 = 4;
  localparam int PRIO_PORT2 = 1;

  // Synchroniser idle values: pin high, fault low
  localparam logic [1:0] SYNC_RST_VAL = 2'h1;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    SLEEP_LEVEL_ZERO,
    SLEEP_LEVEL_ONE,
    SLEEP_LEVEL_TWO,
    SLEEP_LEVEL_THREE,
    SLEEP_LEVEL_FOUR
  } sic_mode_t;

endpackage

/* File: rtl/sic_vec_if.sv */
`timescale 1ns/100ps
// Request lines and chosen vector between controller and arbiter
interface sic_vec_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic [15:0] req;
  logic valid;
  logic [3:0] prio;
  logic [15:0] vec_addr;
  modport arb (input clk, input rst_n, input req,
               output valid, output prio, output vec_addr);
  modport user (output req, input valid, input prio, input vec_addr);
endinterface

/* File: rtl/sic_vec_arb.sv */
`timescale 1ns/100ps
module sic_vec_arb (
  sic_vec_if.arb vi
);
  import sic_pkg::*;

  // Highest set request wins
  // top number wins
  always_comb begin
    vi.valid = 1'b0;
    vi.prio = 4'h0;
    for (int i = 0; i < NUM_PRIO; i++) begin
      if (vi.req[i]) begin
        vi.valid = 1'b1;
        vi.prio = 4'(i);
      end
    end
  end

  // One 16-bit word per vector, table ends at the top address
  // word-spaced entries
  assign vi.vec_addr = VEC_BASE_ADDR + {11'h000, vi.prio, 1'b0};

  prio_top_a: assert property (
    @(posedge vi.clk) disable iff (!vi.rst_n)
    vi.valid |-> ((vi.req >> vi.prio) == 16'h0001))
    else $error("chosen priority is not the highest request");

  vec_word_a: assert property (
    @(posedge vi.clk) disable iff (!vi.rst_n)
    (vi.valid && vi.prio == 4'hF) |-> (vi.vec_addr == RESET_VEC_ADDR))
    else $error("top priority does not map to the reset vector");

  idle_zero_a: assert property (
    @(posedge vi.clk) disable iff (!vi.rst_n)
    (vi.req == 16'h0000) |-> (!vi.valid && vi.vec_addr == VEC_BASE_ADDR))
    else $error("vector presented without a request");

  multi_req_c: cover property (
    @(posedge vi.clk) disable iff (!vi.rst_n)
    vi.valid && ((vi.req & (vi.req - 16'h0001)) != 16'h0000));

endmodule

/* File: rtl/sic_sfr_ctrl.sv */
// Function
// - Vectors occupy topmost 32 bytes, ending at top
// - Each vector is one 16-bit handler address
// - Blank reset vector sends device to deepest sleep
// - All reset causes share top-priority reset vector; only power-up clear causes request it here, power-on reset raises no request
// - Pin NMI, osc fault, flash violation share 14
// - Individual enable gates NMI group, GIE does not
// - Fetch from register or unused space resets
// - Converter 12, watchdog 10, receive 9, transmit 8
// - Compare-0 at 6; other compares, overflow at 5
// - Eight port-1 flags share priority 4
// - Port-2 flags priority 1; lowest vector priority 0
// - Interrupt wakes; return restores previous sleep level
// - Levels 0,1 stop CPU, main clock; level 1 also DC generator if unused
// - Levels 2,3 also stop sub-main clock
// - Level 4 stops everything including crystal
// - Enable byte one holds six enable bits
// - Watchdog enable only counts in interval mode
// - Transmit flag set, receive flag cleared by clear
// - Oscillator fault flag set by fault, clear
// - Watchdog flag: overflow or key violation sets
// - Power-on-only bits survive the power-up clear
// - Module enable: transmit bit 7, receive/sync bit 6
// - Unassigned register bits are not built
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
module sic_sfr_ctrl (
  // Clock and power-on reset
  input wire logic MCLK,
  input wire logic RSTN,
  // Avalon-MM slave
  input wire logic [sic_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [sic_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [sic_pkg::DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Pins and analog sources
  input wire logic PIN_RST_NMI_N,
  input wire logic OSC_FAULT_IN,
  // CPU side
  input wire logic CPU_GIE,
  input wire logic CPU_RETI,
  input wire logic CPU_FETCH_VALID,
  input wire logic [15:0] CPU_FETCH_ADDR,
  input wire logic [15:0] RESET_VEC_WORD,
  // Peripheral events and requests
  input wire logic PIN_NMI_SEL,
  input wire logic WDOG_IVL_MODE,
  input wire logic WDOG_OVF_EVT,
  input wire logic FLASH_KEY_VIOL,
  input wire logic FLASH_ACCV_FLAG,
  input wire logic SER_TX_EVT,
  input wire logic SER_RX_EVT,
  input wire logic SER_SYNC_MODE,
  input wire logic ADC_IRQ,
  input wire logic TMR_CC0_IRQ,
  input wire logic [2:0] TMR_GRP_IRQ,
  input wire logic [7:0] PORT1_IRQ,
  input wire logic [2:0] PORT2_IRQ,
  // Interrupt answer to the CPU
  output logic IRQ_REQ,
  output logic [3:0] IRQ_PRIO,
  output logic [15:0] IRQ_VEC_ADDR,
  output logic SYS_PUC,
  // Clock and power controls
  output logic CPU_RUN,
  output logic MAIN_CLK_EN,
  output logic SUB_MAIN_CLK_EN,
  output logic AUX_CLK_EN,
  output logic DC_GEN_EN,
  output logic XTAL_EN,
  // Serial module enables
  output logic SER_TX_MOD_EN,
  output logic SER_RX_MOD_EN,
  output logic SER_SYNC_MOD_EN
);
  import sic_pkg::*;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  logic [1:0] sync1_reg; // First synchroniser stage
  logic [1:0] sync2_reg; // Second synchroniser stage
  logic pin_prev_reg; // Delayed pin for edge detect
  logic pin_fall; // Pin went low
  logic puc_req; // Any power-up clear cause
  logic puc_reg; // Registered power-up clear
  logic boot_reg; // First cycle after power-on
  logic pin_rst_reg; // Clear was caused by the reset pin
  logic fetch_bad; // Fetch from forbidden space
  logic wait_reg; // Bus wait state
  logic [DATA_W-1:0] rdata_reg; // Bus read data
  logic [7:0] rd_mux; // Selected register byte
  logic wr_fire; // Write takes effect
  logic [7:0] wbyte; // Low byte of write data
  logic [7:0] ie_reg; // irq_enable_one
  logic [7:0] ifg_reg; // irq_flag_one
  logic [7:0] ifg_next; // Flag next value
  logic [7:0] ifg_set; // Hardware set events
  logic [7:0] me_reg; // module_enable_one
  logic dco_used_reg; // Oscillator used in active mode
  sic_mode_t mode_reg; // Current operating mode
  sic_mode_t saved_reg; // Mode to restore on return
  logic [15:0] req_vec; // Gated requests by priority
  logic irq_req_reg; // Registered request
  logic [3:0] irq_prio_reg; // Registered priority
  logic [15:0] irq_vec_reg; // Registered vector address
  logic cpu_run_reg; // CPU clock gate
  logic main_clk_reg; // Main clock gate
  logic sub_clk_reg; // Sub-main clock gate
  logic aux_clk_reg; // Auxiliary clock gate
  logic dc_gen_reg; // DC generator enable
  logic xtal_reg; // Crystal enable
  logic ser_tx_en_reg; // Transmit module enable out
  logic ser_rx_en_reg; // Receive module enable out
  logic ser_sync_en_reg; // Sync module enable out

  sic_vec_if vi (.clk(MCLK), .rst_n(RSTN));
  sic_vec_arb u_arb (.vi(vi));

  // Two-stage sync of pin and fault, then edge stage
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_reg <= SYNC_RST_VAL;
      sync2_reg <= SYNC_RST_VAL;
      pin_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= {OSC_FAULT_IN, PIN_RST_NMI_N};
      sync2_reg <= sync1_reg;
      pin_prev_reg <= sync2_reg[0];
    end
  end

  assign pin_fall = pin_prev_reg && !sync2_reg[0];

  // Fetch outside code, RAM and info space is illegal
  // forbidden fetch check
  assign fetch_bad = CPU_FETCH_VALID &&
    ((CPU_FETCH_ADDR <= SFR_REGION_END) ||
     (CPU_FETCH_ADDR > RAM_END && CPU_FETCH_ADDR < INFO_START) ||
     (CPU_FETCH_ADDR > INFO_END && CPU_FETCH_ADDR < CODE_START));

  assign puc_req = (pin_fall && !PIN_NMI_SEL) ||
    (WDOG_OVF_EVT && !WDOG_IVL_MODE) || FLASH_KEY_VIOL || fetch_bad;

  // Power-up clear pulse and power-on marker
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      puc_reg <= 1'b0;
      boot_reg <= 1'b1;
      pin_rst_reg <= 1'b0;
    end else begin
      puc_reg <= puc_req;
      boot_reg <= 1'b0;
      pin_rst_reg <= pin_fall && !PIN_NMI_SEL;
    end
  end

  bad_fetch_a: assert property (
    (CPU_FETCH_VALID && CPU_FETCH_ADDR <= SFR_REGION_END) |=> SYS_PUC)
    else $error("fetch from register space did not reset");

  key_puc_a: assert property (
    FLASH_KEY_VIOL |=> (puc_reg ##1 (IRQ_PRIO == 4'hF)))
    else $error("key violation did not raise the reset vector");

  // Bus: one wait cycle, then the access completes
  assign wr_fire = AVS_WRITE && !wait_reg && AVS_BYTEENABLE[0];
  assign wbyte = AVS_WRITEDATA[7:0];

  // Read mux, unbuilt bits and registers read zero
  // zero for unassigned bits
  always_comb begin
    case (AVS_ADDRESS)
      IDX_IRQ_ENABLE_ONE: rd_mux = ie_reg & IE1_MASK;
      IDX_IRQ_FLAG_ONE: rd_mux = ifg_reg & IRQ_FLAG_ONE_MASK;
      IDX_MODULE_ENABLE_ONE: rd_mux = me_reg & ME1_MASK;
      IDX_SLEEP_CTRL: rd_mux = {4'h0, dco_used_reg, mode_reg};
      IDX_SLEEP_STAT: rd_mux = {mode_reg, irq_req_reg, irq_prio_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  // Wait-state handshake and read data capture
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else if ((AVS_READ || AVS_WRITE) && wait_reg) begin
      wait_reg <= 1'b0;
      rdata_reg <= {24'h000000, rd_mux};
    end else begin
      wait_reg <= 1'b1;
    end
  end

  bus_answer_a: assert property (
    ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST
    ##1 AVS_WAITREQUEST)
    else $error("bus answer not one cycle after request");

  // Interrupt enables, cleared by every power-up clear
  // six enable bits
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ie_reg <= IE1_RST_VAL;
    end else if (puc_reg) begin
      ie_reg <= IE1_RST_VAL;
    end else if (wr_fire && AVS_ADDRESS == IDX_IRQ_ENABLE_ONE) begin
      ie_reg <= wbyte & IE1_MASK;
    end
  end

  // Module enables, cleared by every power-up clear
  // serial enables
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      me_reg <= ME1_RST_VAL;
    end else if (puc_reg) begin
      me_reg <= ME1_RST_VAL;
    end else if (wr_fire && AVS_ADDRESS == IDX_MODULE_ENABLE_ONE) begin
      me_reg <= wbyte & ME1_MASK;
    end
  end

  // Hardware set events per flag bit
  // watchdog overflow or key
  always_comb begin
    ifg_set = 8'h00;
    ifg_set[BIT_SER_TX] = SER_TX_EVT;
    ifg_set[BIT_SER_RX] = SER_RX_EVT;
    ifg_set[BIT_PIN_NMI] = pin_fall && PIN_NMI_SEL;
    ifg_set[BIT_EXT_RESET] = pin_fall && !PIN_NMI_SEL;
    ifg_set[BIT_OSC_FAULT] = sync2_reg[1];
    ifg_set[BIT_WDOG] = WDOG_OVF_EVT || FLASH_KEY_VIOL;
  end

  // Flag next value: a set always beats a clear
  // power-on bits kept
  always_comb begin
    if (puc_reg) begin
      ifg_next = (ifg_reg & ~IRQ_FLAG_ONE_PUC_MASK) | IRQ_FLAG_ONE_PUC_VAL;
      // pin reset also clears watchdog flag
      if (pin_rst_reg) begin
        ifg_next[BIT_WDOG] = 1'b0;
      end
    end else if (wr_fire && AVS_ADDRESS == IDX_IRQ_FLAG_ONE) begin
      ifg_next = wbyte & IRQ_FLAG_ONE_MASK;
    end else begin
      ifg_next = ifg_reg;
    end
    ifg_next = ifg_next | ifg_set;
  end

  // Flag register, power-on value only under RSTN
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ifg_reg <= IRQ_FLAG_ONE_POR_VAL;
    end else begin
      ifg_reg <= ifg_next;
    end
  end

  tx_puc_a: assert property (
    puc_reg |=> (ifg_reg[BIT_SER_TX] && ifg_reg[BIT_OSC_FAULT]))
    else $error("power-up clear did not set transmit and fault");

  wdog_keep_a: assert property (
    (puc_reg && !pin_rst_reg &&
     !(wr_fire && AVS_ADDRESS == IDX_IRQ_FLAG_ONE))
    |=> (ifg_reg[BIT_WDOG] >= $past(ifg_reg[BIT_WDOG])))
    else $error("power-up clear cleared the watchdog flag");

  // Gated request lines, one per vector priority
  // NMI group ignores GIE
  always_comb begin
    req_vec = 16'h0000;
    req_vec[PRIO_RESET] = puc_reg;
    req_vec[PRIO_NMI] =
      (ifg_reg[BIT_PIN_NMI] && ie_reg[BIT_PIN_NMI]) ||
      (ifg_reg[BIT_OSC_FAULT] && ie_reg[BIT_OSC_FAULT]) ||
      (FLASH_ACCV_FLAG && ie_reg[BIT_FLASH_VIOL]);
    req_vec[PRIO_ADC] = ADC_IRQ && CPU_GIE;
    req_vec[PRIO_WDOG] = ifg_reg[BIT_WDOG] && ie_reg[BIT_WDOG] &&
      WDOG_IVL_MODE && CPU_GIE;
    req_vec[PRIO_SER_RX] = ifg_reg[BIT_SER_RX] && ie_reg[BIT_SER_RX] &&
      CPU_GIE;
    req_vec[PRIO_SER_TX] = ifg_reg[BIT_SER_TX] && ie_reg[BIT_SER_TX] &&
      CPU_GIE;
    req_vec[PRIO_TMR_CC0] = TMR_CC0_IRQ && CPU_GIE;
    req_vec[PRIO_TMR_GRP] = (|TMR_GRP_IRQ) && CPU_GIE;
    req_vec[PRIO_PORT1] = (|PORT1_IRQ) && CPU_GIE;
    req_vec[PRIO_PORT2] = (|PORT2_IRQ) && CPU_GIE;
  end

  assign vi.req = req_vec;

  nmi_no_gie_a: assert property (
    (ifg_reg[BIT_PIN_NMI] && ie_reg[BIT_PIN_NMI] && !puc_reg)
    |=> (IRQ_REQ && IRQ_PRIO == 4'hE))
    else $error("enabled pin NMI not presented at 14");

  gie_gate_a: assert property (
    (!CPU_GIE && !puc_reg && req_vec[PRIO_NMI] == 1'b0) |=> !IRQ_REQ)
    else $error("maskable request passed with GIE low");

  wdog_mode_a: assert property (
    !WDOG_IVL_MODE |-> !req_vec[PRIO_WDOG])
    else $error("watchdog request in reset mode");

  // Registered interrupt answer to the CPU
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_req_reg <= 1'b0;
      irq_prio_reg <= 4'h0;
      irq_vec_reg <= VEC_BASE_ADDR;
    end else begin
      irq_req_reg <= vi.valid;
      irq_prio_reg <= vi.prio;
      irq_vec_reg <= vi.vec_addr;
    end
  end

  // Mode and saved mode: clear, blank vector, wake, return, write
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_reg <= MODE_ACTIVE;
      saved_reg <= MODE_ACTIVE;
    end else if (puc_reg) begin
      mode_reg <= MODE_ACTIVE;
      saved_reg <= MODE_ACTIVE;
    end else if (boot_reg && RESET_VEC_WORD == BLANK_WORD) begin
      mode_reg <= SLEEP_LEVEL_FOUR;
    end else if (vi.valid && mode_reg != MODE_ACTIVE) begin
      saved_reg <= mode_reg;
      mode_reg <= MODE_ACTIVE;
    end else if (CPU_RETI) begin
      mode_reg <= saved_reg;
      saved_reg <= MODE_ACTIVE;
    end else if (wr_fire && AVS_ADDRESS == IDX_SLEEP_CTRL &&
                 wbyte[2:0] <= MODE_CODE_MAX) begin
      mode_reg <= sic_mode_t'(wbyte[2:0]);
    end
  end

  // Oscillator usage bit, kept across clears
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      dco_used_reg <= 1'b1;
    end else if (wr_fire && AVS_ADDRESS == IDX_SLEEP_CTRL) begin
      dco_used_reg <= wbyte[CTRL_DCO_USED_BIT];
    end
  end

  blank_vec_a: assert property (
    (boot_reg && RESET_VEC_WORD == BLANK_WORD && !puc_reg)
    |=> mode_reg == SLEEP_LEVEL_FOUR ##2 !CPU_RUN)
    else $error("blank reset vector did not enter deepest sleep");

  wake_a: assert property (
    (mode_reg != MODE_ACTIVE && vi.valid && !puc_reg && !boot_reg)
    |=> (mode_reg == MODE_ACTIVE && saved_reg == $past(mode_reg)))
    else $error("pending interrupt did not wake the device");

  reti_a: assert property (
    (mode_reg == MODE_ACTIVE && CPU_RETI && !puc_reg && !boot_reg)
    |=> (mode_reg == $past(saved_reg)))
    else $error("return did not restore the saved level");

  // Clock and generator gates by mode
  // levels zero and one
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      {cpu_run_reg, main_clk_reg, sub_clk_reg} <= 3'h7;
      {aux_clk_reg, dc_gen_reg, xtal_reg} <= 3'h7;
    end else begin
      case (mode_reg)
        MODE_ACTIVE: begin
          {cpu_run_reg, main_clk_reg, sub_clk_reg} <= 3'h7;
          {aux_clk_reg, dc_gen_reg, xtal_reg} <= 3'h7;
        end
        SLEEP_LEVEL_ZERO: begin
          {cpu_run_reg, main_clk_reg, sub_clk_reg} <= 3'h1;
          {aux_clk_reg, dc_gen_reg, xtal_reg} <= 3'h7;
        end
        SLEEP_LEVEL_ONE: begin
          {cpu_run_reg, main_clk_reg, sub_clk_reg} <= 3'h1;
          {aux_clk_reg, dc_gen_reg, xtal_reg} <= {1'b1, dco_used_reg, 1'b1};
        end
        SLEEP_LEVEL_TWO: begin
          {cpu_run_reg, main_clk_reg, sub_clk_reg} <= 3'h0;
          {aux_clk_reg, dc_gen_reg, xtal_reg} <= 3'h7;
        end
        SLEEP_LEVEL_THREE: begin
          {cpu_run_reg, main_clk_reg, sub_clk_reg} <= 3'h0;
          {aux_clk_reg, dc_gen_reg, xtal_reg} <= 3'h5;
        end
        default: begin
          {cpu_run_reg, main_clk_reg, sub_clk_reg} <= 3'h0;
          {aux_clk_reg, dc_gen_reg, xtal_reg} <= 3'h0;
        end
      endcase
    end
  end

  sleep_level_four_stop_a: assert property (
    (mode_reg == SLEEP_LEVEL_FOUR) |=>
    !(AUX_CLK_EN || DC_GEN_EN || XTAL_EN || MAIN_CLK_EN))
    else $error("deepest sleep left a clock running");

  lpm23_a: assert property (
    (mode_reg == SLEEP_LEVEL_TWO || mode_reg == SLEEP_LEVEL_THREE) |=>
    (!SUB_MAIN_CLK_EN && AUX_CLK_EN &&
     DC_GEN_EN == ($past(mode_reg) == SLEEP_LEVEL_TWO)))
    else $error("levels two or three gated wrongly");

  lpm01_a: assert property (
    (mode_reg == SLEEP_LEVEL_ZERO || mode_reg == SLEEP_LEVEL_ONE) |=>
    (!CPU_RUN && !MAIN_CLK_EN && SUB_MAIN_CLK_EN && AUX_CLK_EN))
    else $error("levels zero or one gated wrongly");

  // Serial module enables, bit 6 split by sync mode
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ser_tx_en_reg <= 1'b0;
      ser_rx_en_reg <= 1'b0;
      ser_sync_en_reg <= 1'b0;
    end else begin
      ser_tx_en_reg <= me_reg[BIT_SER_TX];
      ser_rx_en_reg <= me_reg[BIT_SER_RX] && !SER_SYNC_MODE;
      ser_sync_en_reg <= me_reg[BIT_SER_RX] && SER_SYNC_MODE;
    end
  end

  wake_c: cover property (mode_reg == SLEEP_LEVEL_THREE ##1
    mode_reg == MODE_ACTIVE);
  puc_c: cover property (puc_reg ##2 IRQ_PRIO == 4'hF);
  reti_c: cover property (CPU_RETI && saved_reg != MODE_ACTIVE);

  // Outputs straight from flip-flops
  assign AVS_READDATA = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign IRQ_REQ = irq_req_reg;
  assign IRQ_PRIO = irq_prio_reg;
  assign IRQ_VEC_ADDR = irq_vec_reg;
  assign SYS_PUC = puc_reg;
  assign CPU_RUN = cpu_run_reg;
  assign MAIN_CLK_EN = main_clk_reg;
  assign SUB_MAIN_CLK_EN = sub_clk_reg;
  assign AUX_CLK_EN = aux_clk_reg;
  assign DC_GEN_EN = dc_gen_reg;
  assign XTAL_EN = xtal_reg;
  assign SER_TX_MOD_EN = ser_tx_en_reg;
  assign SER_RX_MOD_EN = ser_rx_en_reg;
  assign SER_SYNC_MOD_EN = ser_sync_en_reg;

endmodule

/* File: bench/sic_cpu_model.sv */
`timescale 1ns/100ps
// CPU stand-in: gives the global enable, returns after a wake
module sic_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench command and observed run state
  input wire logic gie_cmd,
  input wire logic run,
  // Answers to the controller
  output logic gie,
  output logic reti
);
  logic run_reg; // Run state one cycle ago
  logic [3:0] cnt_reg; // Handler length countdown
  assign gie = gie_cmd;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'h1;
      cnt_reg <= 4'h0;
      reti <= 1'h0;
    end else begin
      run_reg <= run;
      reti <= (cnt_reg == 4'h1);
      if (run && !run_reg) begin
        cnt_reg <= 4'hA;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule

/* File: bench/sic_sfr_ctrl_tb_top.sv */
`timescale 1ns/100ps
module sic_sfr_ctrl_tb_top;
  logic MCLK = 0, RSTN = 0, AVS_READ = 0, AVS_WRITE = 0, CPU_GIE, CPU_RETI;
  logic CPU_FETCH_VALID = 0, gie_cmd = 0, AVS_WAITREQUEST, IRQ_REQ;
  logic [2:0] AVS_ADDRESS = 0;
  logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA;
  logic [15:0] CPU_FETCH_ADDR = 16'hC000, IRQ_VEC_ADDR;
  logic [7:0] src = 0; // Peripheral source lines
  logic [3:0] IRQ_PRIO;
  logic [5:0] clk_en; // Run and clock enables
  logic [2:0] mod_en; // Serial module enables
  logic pin_n = 1, nmi_sel = 0, ivl = 0, key = 0, puc_seen; // Pin and clear
  int failures = 0, cmp_count = 0;
  localparam logic [5:0] SLP [5] = '{6'h0F, 6'h0D, 6'h07, 6'h05, 6'h00};
  localparam logic [3:0] PRI [5] = '{4'hC, 4'h6, 4'h5, 4'h4, 4'h1};
  localparam logic [15:0] VEC [5] = '{16'hFFF8, 16'hFFEC, 16'hFFEA,
    16'hFFE8, 16'hFFE2};
  sic_sfr_ctrl u_sic_sfr_ctrl (.MCLK, .RSTN, .AVS_ADDRESS, .AVS_READ,
    .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE(4'hF), .AVS_READDATA,
    .AVS_WAITREQUEST, .PIN_RST_NMI_N(pin_n), .OSC_FAULT_IN(1'h0), .CPU_GIE,
    .CPU_RETI, .CPU_FETCH_VALID, .CPU_FETCH_ADDR, .RESET_VEC_WORD(16'hC000),
    .PIN_NMI_SEL(nmi_sel), .WDOG_IVL_MODE(ivl), .WDOG_OVF_EVT(src[7]),
    .FLASH_KEY_VIOL(key), .FLASH_ACCV_FLAG(src[5]), .SER_TX_EVT(1'h0),
    .SER_RX_EVT(src[6]), .SER_SYNC_MODE(1'h0), .ADC_IRQ(src[0]),
    .TMR_CC0_IRQ(src[1]), .TMR_GRP_IRQ({3{src[2]}}),
    .PORT1_IRQ({8{src[3]}}), .PORT2_IRQ({3{src[4]}}), .IRQ_REQ, .IRQ_PRIO,
    .IRQ_VEC_ADDR, .SYS_PUC(puc_seen), .CPU_RUN(clk_en[5]),
    .MAIN_CLK_EN(clk_en[4]),
    .SUB_MAIN_CLK_EN(clk_en[3]), .AUX_CLK_EN(clk_en[2]),
    .DC_GEN_EN(clk_en[1]), .XTAL_EN(clk_en[0]), .SER_TX_MOD_EN(mod_en[2]),
    .SER_RX_MOD_EN(mod_en[1]), .SER_SYNC_MOD_EN(mod_en[0]));
  sic_cpu_model u_sic_cpu_model (.clk(MCLK), .rst_n(RSTN), .gie_cmd,
    .run(clk_en[5]), .gie(CPU_GIE), .reti(CPU_RETI));
  // Clock, 8 ns period
  always #4 MCLK = ~MCLK;
  // Compare and count
  task automatic chk(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang cut short
  task automatic stuck;
    failures++;
    $display("wrong value at %0t: no answer", $time);
    complete_run;
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do begin
      @(posedge MCLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'h0 && n < 50);
    if (n >= 50) stuck;
    q = AVS_READDATA[7:0];
    AVS_WRITE <= 1'h0;
    AVS_READ <= 1'h0;
    @(posedge MCLK);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'h0, a, 8'h00, q);
    chk({8'h0, q}, {8'h0, e});
  endtask
  // Bounded wait on the run enable
  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (clk_en[5] !== v && n < 100) begin
      @(posedge MCLK);
      n++;
    end
    if (n >= 100) stuck;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge MCLK);
    RSTN <= 1'h1;
    @(posedge MCLK);
    rd(3'h0, 8'h00);
    rd(3'h2, 8'h86);
    wr(3'h0, 8'hFF);
    rd(3'h0, 8'hF3);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h00);
    wr(3'h4, 8'hFF);
    rd(3'h4, 8'hC0);
    chk({13'h0, mod_en}, 16'h0006);
    wr(3'h0, 8'h00);
    $display("test registers done");
    gie_cmd <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      src <= 8'h01 << i;
      repeat (2) @(posedge MCLK);
      chk({12'h0, IRQ_PRIO}, {12'h0, PRI[i]});
      chk(IRQ_VEC_ADDR, VEC[i]);
    end
    src <= 8'h1F;
    repeat (2) @(posedge MCLK);
    chk({12'h0, IRQ_PRIO}, 16'h000C);
    gie_cmd <= 1'h0;
    src <= 8'h20;
    wr(3'h0, 8'h20);
    repeat (2) @(posedge MCLK);
    chk({IRQ_REQ, IRQ_VEC_ADDR[14:0]}, 16'hFFFC);
    src <= 8'h00;
    wr(3'h0, 8'h00);
    $display("test priorities done");
    for (int m = 1; m < 6; m++) begin
      wr(3'h6, m[7:0]);
      repeat (2) @(posedge MCLK);
      chk({10'h0, clk_en}, {10'h0, SLP[m-1]});
    end
    wr(3'h6, 8'h03);
    gie_cmd <= 1'h1;
    src <= 8'h08;
    wait_run(1'h1);
    src <= 8'h00;
    wait_run(1'h0);
    repeat (2) @(posedge MCLK);
    chk({10'h0, clk_en}, 16'h0007);
    $display("test sleep done");
    ivl <= 1'h1;
    src <= 8'hC0;
    @(posedge MCLK);
    src <= 8'h00;
    nmi_sel <= 1'h1;
    pin_n <= 1'h0;
    repeat (4) @(posedge MCLK);
    pin_n <= 1'h1;
    repeat (2) @(posedge MCLK);
    rd(3'h2, 8'hD7);
    nmi_sel <= 1'h0;
    CPU_FETCH_ADDR <= 16'h0100;
    CPU_FETCH_VALID <= 1'h1;
    @(posedge MCLK);
    CPU_FETCH_VALID <= 1'h0;
    @(posedge MCLK);
    chk({15'h0, puc_seen}, 16'h0001);
    repeat (3) @(posedge MCLK);
    rd(3'h2, 8'h87);
    rd(3'h4, 8'h00);
    wr(3'h2, 8'h00);
    key <= 1'h1;
    @(posedge MCLK);
    key <= 1'h0;
    repeat (3) @(posedge MCLK);
    rd(3'h2, 8'h83);
    pin_n <= 1'h0;
    repeat (4) @(posedge MCLK);
    pin_n <= 1'h1;
    repeat (3) @(posedge MCLK);
    rd(3'h2, 8'h8A);
    $display("test clear done");
    complete_run;
  end
endmodule
